// ===== include/lsp_pkg.sv
package lsp_pkg;

    // Register byte offsets
    localparam logic [4:0] OFS_STATUS = 5'h00;
    localparam logic [4:0] OFS_CTRL   = 5'h08;
    localparam logic [4:0] OFS_BAUDI  = 5'h0c;
    localparam logic [4:0] OFS_DATA   = 5'h10;
    localparam logic [4:0] OFS_BAUDF  = 5'h14;
    localparam logic [4:0] OFS_WAKE   = 5'h18;

    // Control field positions
    localparam int CB_PSEL  = 0;
    localparam int CB_TRANSMIT_ENABLE  = 1;
    localparam int CB_FLUSH = 2;
    localparam int CB_PDIS  = 3;
    localparam int CB_LOOP  = 4;
    localparam int CB_DTX   = 5;
    localparam int CB_DRX   = 6;
    localparam int CB_WSTP  = 7;
    localparam int CB_RTSTH = 8;
    localparam int CB_CTS_FLOW_ENABLE = 10;
    localparam int CB_RTS_FLOW_ENABLE = 11;
    localparam int CB_WSEL  = 12;
    localparam int CB_SMP   = 14;
    localparam int CTRL_W   = 15;

    // Status field positions
    localparam int SB_PEF  = 0;
    localparam int SB_TXC  = 1;
    localparam int SB_OV   = 2;
    localparam int SB_FU   = 3;
    localparam int SB_HF   = 4;
    localparam int SB_NE   = 5;
    localparam int SB_CTS  = 6;
    localparam int SB_WUF  = 7;
    localparam int SB_NF   = 8;
    localparam int STAT_W  = 9;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST  = 15'h0200;
    localparam logic [15:0]       BAUDI_RST = 16'h0174;
    localparam logic [7:0]        BAUDF_RST = 8'h00;
    localparam logic [31:0]       WAKE_RST  = 32'h0000_0000;

    // Receive buffer and thresholds
    localparam int         FIFO_DEPTH = 8;
    localparam int         FIFO_AW    = 3;
    localparam logic [3:0] TH_HALF    = 4'h4;
    localparam logic [3:0] TH_3Q      = 4'h6;
    localparam logic [3:0] TH_FULL    = 4'h8;

    // Field encodings
    localparam logic [1:0] WS_START = 2'h0;
    localparam logic [1:0] WS_NONEMPTY = 2'h1;
    localparam logic [1:0] WS_BYTE  = 2'h2;
    localparam logic [1:0] RT_HALF  = 2'h0;
    localparam logic [1:0] RT_FULL  = 2'h2;

    // Frame shape
    localparam logic [2:0] LAST_BIT    = 3'h7;
    localparam logic [2:0] FRAME_BYTES = 3'h4;
    localparam int         SYNC_STAGES = 3;

endpackage

// ===== rtl/lsp_bit_timer.sv
`timescale 1ns/1ns
module lsp_bit_timer
    import lsp_pkg::*;
(
    // Clock and control
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    input  wire logic        i_clk_en,
    input  wire logic        i_restart,
    // Divisor fields
    input  wire logic [15:0] i_divisor,
    input  wire logic [7:0]  i_fraction,
    // Bit timing
    output logic      [15:0] o_count,
    output logic             o_bit_end
);
    logic [7:0]  acc;
    logic [8:0]  acc_sum;
    logic [15:0] last;
    logic [15:0] div_safe;

    // Fraction accumulator: a carry stretches this bit by one clock
    assign acc_sum   = {1'b0, acc} + {1'b0, i_fraction};
    assign div_safe  = (i_divisor == 16'h0000) ? 16'h0001 : i_divisor;
    assign last      = div_safe - 16'h0001 + {15'h0000, acc_sum[8]};
    assign o_bit_end = (o_count == last) && !i_restart;

    // Count within the bit, restart re-aligns to a start edge
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_count <= 16'h0000;
            acc     <= 8'h00;
        end else if (i_clk_en) begin
            if (i_restart) begin
                o_count <= 16'h0000;
                acc     <= 8'h00;
            end else if (o_bit_end) begin
                o_count <= 16'h0000;
                acc     <= acc_sum[7:0];
            end else begin
                o_count <= o_count + 16'h0001;
            end
        end
    end

endmodule

// ===== rtl/lsp_serial_port.sv
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ns
module lsp_serial_port
    import lsp_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    input  wire logic        i_clk_en,
    // Avalon-MM slave
    input  wire logic [4:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic [3:0]  i_byteenable,
    output logic      [31:0] o_readdata,
    output logic             o_waitrequest,
    // Serial lines
    input  wire logic        i_rx,
    input  wire logic        i_cts,
    output logic             o_tx,
    output logic             o_rts,
    // System side
    output logic             o_wake,
    output logic             o_dma_rx_req,
    output logic             o_dma_tx_req
);
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
    } lsp_rx_state_t;
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
    } lsp_tx_state_t;

    // Registers
    logic [CTRL_W-1:0] ctrl;
    logic [15:0]       baud_int;
    logic [7:0]        baud_frac;
    logic [31:0]       wake_pat;
    logic              flag_nf, flag_wuf, flag_ov, flag_txc, flag_pef;
    logic              ack;

    // Bus decode
    logic [31:0] wmask;
    logic        req, acc_wr, acc_rd;
    logic        sel_stat, sel_ctrl, sel_bi, sel_data, sel_bf, sel_wake;
    logic [31:0] next_rdata;
    logic [31:0] w1c;

    assign req      = i_read | i_write;
    assign acc_wr   = i_write & ack;
    assign acc_rd   = i_read & ack;
    assign sel_stat = (i_address == OFS_STATUS);
    assign sel_ctrl = (i_address == OFS_CTRL);
    assign sel_bi   = (i_address == OFS_BAUDI);
    assign sel_data = (i_address == OFS_DATA);
    assign sel_bf   = (i_address == OFS_BAUDF);
    assign sel_wake = (i_address == OFS_WAKE);
    assign wmask    = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                       {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
    assign w1c      = (acc_wr && sel_stat) ? (i_writedata & wmask) : 32'h0;
    // One wait cycle per access so read data can come from a flop
    assign o_waitrequest = req & ~ack;

    // Control fields
    logic       smp_one, rts_en, cts_en, stop_wake_en;
    logic       dma_rx_en, dma_tx_en, loop_en, par_dis, par_odd, tx_en;
    logic [1:0] wake_sel, rts_th;
    assign smp_one      = ctrl[CB_SMP];
    assign wake_sel     = ctrl[CB_WSEL+1:CB_WSEL];
    assign rts_en       = ctrl[CB_RTS_FLOW_ENABLE];
    assign cts_en       = ctrl[CB_CTS_FLOW_ENABLE];
    assign rts_th       = ctrl[CB_RTSTH+1:CB_RTSTH];
    assign stop_wake_en = ctrl[CB_WSTP];
    assign dma_rx_en    = ctrl[CB_DRX];
    assign dma_tx_en    = ctrl[CB_DTX];
    assign loop_en      = ctrl[CB_LOOP];
    assign par_dis      = ctrl[CB_PDIS];
    assign tx_en        = ctrl[CB_TRANSMIT_ENABLE];
    assign par_odd      = ctrl[CB_PSEL];

    // Receive buffer
    logic [7:0]         fifo_mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wr_ptr, rd_ptr;
    logic [3:0]         fifo_cnt;
    logic               push, pop, flush, fifo_ne, fifo_hf, fifo_fu;
    logic [7:0]         rx_byte;

    assign fifo_ne = (fifo_cnt != 4'h0);
    assign fifo_hf = (fifo_cnt >= TH_HALF);
    assign fifo_fu = (fifo_cnt == TH_FULL);
    assign flush   = acc_wr && sel_ctrl && i_byteenable[0]
                     && i_writedata[CB_FLUSH];
    assign pop     = acc_rd && sel_data && fifo_ne && !flush;

    // Input synchronisers: a change counts once stages two and three agree
    logic [SYNC_STAGES-1:0] rx_sync, cts_sync;
    logic                   rx_pin, cts_pin;
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rx_sync  <= '1;
            cts_sync <= '0;
            rx_pin   <= 1'b1;
            cts_pin  <= 1'b0;
        end else if (i_clk_en) begin
            rx_sync  <= {rx_sync[1:0], i_rx};
            cts_sync <= {cts_sync[1:0], i_cts};
            if (rx_sync[1] == rx_sync[2]) rx_pin <= rx_sync[2];
            if (cts_sync[1] == cts_sync[2]) cts_pin <= cts_sync[2];
        end
    end

    // Loopback takes the transmit line in place of the pin
    logic rx_line;
    assign rx_line = loop_en ? o_tx : rx_pin;

    // Receiver timing and sampling
    lsp_rx_state_t rx_state;
    logic [15:0]   rx_count, half;
    logic          rx_end, rx_restart, start_edge;
    logic [2:0]    smp;
    logic          bit_val, noisy, rx_par;
    logic [2:0]    rx_idx;
    logic [7:0]    rx_shift;

    assign half       = baud_int >> 1;
    assign start_edge = (rx_state == RX_IDLE) && !rx_line;
    assign rx_restart = start_edge;
    // Single-sample mode trusts the middle sample and never flags noise
    assign bit_val = smp_one ? smp[1]
                   : ((smp[0] & smp[1]) | (smp[1] & smp[2]) | (smp[0] & smp[2]));
    assign noisy   = !smp_one && ((smp[0] != smp[1]) || (smp[1] != smp[2]));

    lsp_bit_timer u_rx_timer (
        .i_clock    (i_clock),
        .i_srst     (i_srst),
        .i_clk_en   (i_clk_en),
        .i_restart  (rx_restart),
        .i_divisor  (baud_int),
        .i_fraction (baud_frac),
        .o_count    (rx_count),
        .o_bit_end  (rx_end)
    );

    // Samples around mid-bit
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            smp <= 3'h7;
        end else if (i_clk_en) begin
            if (rx_count == half - 16'h0001) smp[0] <= rx_line;
            if (rx_count == half) smp[1] <= rx_line;
            if (rx_count == half + 16'h0001) smp[2] <= rx_line;
        end
    end

    // Receive frame sequencer
    logic rx_done, rx_noise_ev, rx_perr_ev;
    assign rx_done     = (rx_state == RX_STOP) && rx_end;
    assign push        = rx_done && bit_val && !fifo_fu && !flush;
    assign rx_byte     = rx_shift;
    assign rx_noise_ev = rx_end && (rx_state != RX_IDLE) && noisy;
    assign rx_perr_ev  = (rx_state == RX_PAR) && rx_end
                         && ((^rx_shift ^ par_odd) != bit_val);

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rx_state <= RX_IDLE;
            rx_idx   <= 3'h0;
            rx_shift <= 8'h00;
        end else if (i_clk_en) begin
            case (rx_state)
                RX_IDLE: begin
                    if (start_edge) rx_state <= RX_START;
                end
                RX_START: begin
                    if (rx_end) begin
                        rx_idx   <= 3'h0;
                        rx_state <= bit_val ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_end) begin
                        rx_shift <= {bit_val, rx_shift[7:1]};
                        rx_idx   <= rx_idx + 3'h1;
                        if (rx_idx == LAST_BIT)
                            rx_state <= par_dis ? RX_STOP : RX_PAR;
                    end
                end
                RX_PAR: begin
                    if (rx_end) rx_state <= RX_STOP;
                end
                RX_STOP: begin
                    if (rx_end) rx_state <= RX_IDLE;
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // Buffer pointers and storage
    always_ff @(posedge i_clock) begin
        if (i_srst || (i_clk_en && flush)) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            fifo_cnt <= 4'h0;
        end else if (i_clk_en) begin
            if (push) wr_ptr <= wr_ptr + FIFO_AW'(1);
            if (pop) rd_ptr <= rd_ptr + FIFO_AW'(1);
            fifo_cnt <= fifo_cnt + {3'h0, push} - {3'h0, pop};
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_clk_en && push) fifo_mem[wr_ptr] <= rx_byte;
    end

    // RTS level from buffer fill
    logic rts_hit;
    assign rts_hit = rts_th[0] ? (fifo_cnt >= TH_3Q)
                   : (rts_th == RT_HALF) ? fifo_hf : fifo_fu;
    always_ff @(posedge i_clock) begin
        if (i_srst) o_rts <= 1'b0;
        else if (i_clk_en) o_rts <= rts_en && rts_hit;
    end

    // Wake detection; pattern byte 0 is the oldest of a four-byte frame
    logic [31:0] win;
    logic [2:0]  win_cnt;
    logic        wake_ev, byte_ev, frame_ev;
    assign byte_ev  = push && (rx_byte == wake_pat[7:0]);
    assign frame_ev = push && (win_cnt >= FRAME_BYTES - 3'h1)
                      && ({rx_byte, win[31:8]} == wake_pat);
    always_comb begin
        case (wake_sel)
            WS_START:    wake_ev = start_edge;
            WS_NONEMPTY: wake_ev = push && !fifo_ne;
            WS_BYTE:     wake_ev = byte_ev;
            default:     wake_ev = frame_ev;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            win     <= 32'h0;
            win_cnt <= 3'h0;
            o_wake  <= 1'b0;
        end else if (i_clk_en) begin
            if (push) begin
                win <= {rx_byte, win[31:8]};
                if (win_cnt != FRAME_BYTES) win_cnt <= win_cnt + 3'h1;
            end
            o_wake <= stop_wake_en && wake_ev;
        end
    end

    // Transmitter
    lsp_tx_state_t tx_state;
    logic [7:0]    tx_hold, tx_shift;
    logic          tx_full, tx_go, tx_end, tx_par;
    logic [2:0]    tx_idx;
    logic          tx_load;
    assign tx_load = acc_wr && sel_data && i_byteenable[0];
    // CTS is checked only between frames, so a frame in flight finishes
    assign tx_go   = (tx_state == TX_IDLE) && tx_full && tx_en
                     && !(cts_en && cts_pin);

    lsp_bit_timer u_tx_timer (
        .i_clock    (i_clock),
        .i_srst     (i_srst),
        .i_clk_en   (i_clk_en),
        .i_restart  (tx_go),
        .i_divisor  (baud_int),
        .i_fraction (baud_frac),
        .o_count    (),
        .o_bit_end  (tx_end)
    );

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            tx_state <= TX_IDLE;
            tx_hold  <= 8'h00;
            tx_full  <= 1'b0;
            tx_shift <= 8'h00;
            tx_idx   <= 3'h0;
            tx_par   <= 1'b0;
            o_tx     <= 1'b1;
        end else if (i_clk_en) begin
            if (tx_load) begin
                tx_hold <= i_writedata[7:0];
                tx_full <= 1'b1;
            end else if (tx_go) begin
                tx_full <= 1'b0;
            end
            case (tx_state)
                TX_IDLE: begin
                    o_tx <= 1'b1;
                    if (tx_go) begin
                        tx_shift <= tx_hold;
                        tx_par   <= ^tx_hold ^ par_odd;
                        tx_idx   <= 3'h0;
                        o_tx     <= 1'b0;
                        tx_state <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_end) begin
                        o_tx     <= tx_shift[0];
                        tx_state <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_end) begin
                        tx_shift <= tx_shift >> 1;
                        tx_idx   <= tx_idx + 3'h1;
                        o_tx     <= tx_shift[1];
                        if (tx_idx == LAST_BIT) begin
                            o_tx     <= par_dis ? 1'b1 : tx_par;
                            tx_state <= par_dis ? TX_STOP : TX_PAR;
                        end
                    end
                end
                TX_PAR: begin
                    if (tx_end) begin
                        o_tx     <= 1'b1;
                        tx_state <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (tx_end) tx_state <= TX_IDLE;
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // DMA requests
    assign o_dma_rx_req = dma_rx_en && fifo_ne;
    assign o_dma_tx_req = dma_tx_en && !tx_full;

    // Sticky flags: a hardware set wins over a same-cycle software clear
    logic tx_cmpl_ev;
    assign tx_cmpl_ev = (tx_state == TX_STOP) && tx_end && !tx_full;
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            flag_nf  <= 1'b0;
            flag_wuf <= 1'b0;
            flag_ov  <= 1'b0;
            flag_txc <= 1'b0;
            flag_pef <= 1'b0;
        end else if (i_clk_en) begin
            flag_nf  <= rx_noise_ev | (flag_nf & ~w1c[SB_NF]);
            flag_wuf <= wake_ev | (flag_wuf & ~w1c[SB_WUF]);
            flag_ov  <= (rx_done & fifo_fu) | (flag_ov & ~w1c[SB_OV]);
            flag_txc <= tx_cmpl_ev | (flag_txc & ~w1c[SB_TXC] & ~tx_load);
            flag_pef <= rx_perr_ev | (flag_pef & ~w1c[SB_PEF]);
        end
    end

    // Software registers; flush is a command and is not stored
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            ctrl      <= CTRL_RST;
            baud_int  <= BAUDI_RST;
            baud_frac <= BAUDF_RST;
            wake_pat  <= WAKE_RST;
            ack       <= 1'b0;
        end else if (i_clk_en) begin
            ack <= req & ~ack;
            if (acc_wr && sel_ctrl) begin
                ctrl <= (ctrl & ~wmask[CTRL_W-1:0])
                        | (i_writedata[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
                ctrl[CB_FLUSH] <= 1'b0;
            end
            if (acc_wr && sel_bi)
                baud_int <= (baud_int & ~wmask[15:0]) | (i_writedata[15:0] & wmask[15:0]);
            if (acc_wr && sel_bf && i_byteenable[0])
                baud_frac <= i_writedata[7:0];
            if (acc_wr && sel_wake)
                wake_pat <= (wake_pat & ~wmask) | (i_writedata & wmask);
        end
    end

    // Read mux; unmapped offsets and an empty buffer read zero
    always_comb begin
        next_rdata = 32'h0;
        if (sel_stat)
            next_rdata[STAT_W-1:0] = {flag_nf, flag_wuf, cts_pin, fifo_ne,
                                      fifo_hf, fifo_fu, flag_ov, flag_txc, flag_pef};
        else if (sel_ctrl)
            next_rdata[CTRL_W-1:0] = ctrl;
        else if (sel_bi)
            next_rdata[15:0] = baud_int;
        else if (sel_data)
            next_rdata[7:0] = fifo_ne ? fifo_mem[rd_ptr] : 8'h00;
        else if (sel_bf)
            next_rdata[7:0] = baud_frac;
        else if (sel_wake)
            next_rdata = wake_pat;
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) o_readdata <= 32'h0;
        else if (i_clk_en && i_read && !ack) o_readdata <= next_rdata;
    end

endmodule

// ===== sim/lsp_serial_port_props.sv
`timescale 1ns/1ns
module lsp_serial_port_props
    import lsp_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    // Register bus
    input  wire logic [4:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic        o_waitrequest,
    // Lines and requests
    input  wire logic        i_cts,
    input  wire logic        o_tx,
    input  wire logic        o_rts,
    input  wire logic        o_wake,
    input  wire logic        o_dma_rx_req,
    input  wire logic        o_dma_tx_req
);
    logic [14:0] ctl;
    logic [3:0]  cts_hi;
    // Control shadow; assumes full-word writes
    always_ff @(posedge i_clock)
        if (i_srst) ctl <= CTRL_RST;
        else if (i_write && !o_waitrequest && i_address == OFS_CTRL) ctl <= i_writedata[14:0];
    // Cycles with the clear line held off, saturating
    always_ff @(posedge i_clock)
        if (i_srst || !i_cts) cts_hi <= 4'h0;
        else if (cts_hi != 4'hf) cts_hi <= cts_hi + 4'h1;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    a_wait_state: assert property (
        $rose(i_read || i_write) |-> o_waitrequest ##1 !o_waitrequest) else $error("wait state");
    a_idle_free: assert property (
        !(i_read || i_write) |-> !o_waitrequest) else $error("idle stall");
    a_rx_dma_gate: assert property (
        !ctl[CB_DRX] |-> !o_dma_rx_req) else $error("rx dma ungated");
    a_tx_dma_gate: assert property (
        !ctl[CB_DTX] |-> !o_dma_tx_req) else $error("tx dma ungated");
    a_wake_gate: assert property (
        !ctl[CB_WSTP] && !$past(ctl[CB_WSTP]) |-> !o_wake) else $error("wake ungated");
    a_wake_pulse: assert property (
        o_wake |=> !o_wake) else $error("wake too long");
    a_rts_gate: assert property (
        !ctl[CB_RTS_FLOW_ENABLE] && !$past(ctl[CB_RTS_FLOW_ENABLE]) |-> !o_rts) else $error("rts ungated");
    a_tx_gate: assert property (
        !ctl[CB_TRANSMIT_ENABLE] && !$past(ctl[CB_TRANSMIT_ENABLE]) && !$past(ctl[CB_TRANSMIT_ENABLE], 2) |-> !$fell(o_tx))
        else $error("frame while disabled");
    a_cts_hold: assert property (
        ctl[CB_CTS_FLOW_ENABLE] && $past(ctl[CB_CTS_FLOW_ENABLE], 2) && cts_hi > 4'h8 |-> !$fell(o_tx))
        else $error("frame while held off");

    c_wake: cover property (o_wake);
    c_rts: cover property ($rose(o_rts));
    c_rx_dma: cover property (o_dma_rx_req);
endmodule

bind lsp_serial_port lsp_serial_port_props u_props (
    .i_clock(i_clock), .i_srst(i_srst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_waitrequest(o_waitrequest),
    .i_cts(i_cts), .o_tx(o_tx), .o_rts(o_rts), .o_wake(o_wake),
    .o_dma_rx_req(o_dma_rx_req), .o_dma_tx_req(o_dma_tx_req));

// ===== sim/lsp_remote_model.sv
`timescale 1ns/1ns
module lsp_remote_model #(
    parameter int DIV = 16
) (
    // Clock and serial lines
    input  wire logic i_clock,
    input  wire logic i_line_in,
    output logic      o_line_out,
    output logic      o_clear_n
);
    logic [7:0] last = 8'h00;
    int         count = 0;
    // Idle line high; clear low lets the device send
    initial begin
        o_line_out = 1'b1;
        o_clear_n = 1'b0;
    end
    // Start, eight bits low first, stop; no parity bit
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clock);
            o_line_out <= f[i];
            repeat (DIV - 1) @(posedge i_clock);
        end
    endtask
    // Sample device frames mid-bit, off the launching edge
    always begin
        @(negedge i_line_in);
        repeat (DIV / 2) @(negedge i_clock);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(negedge i_clock);
            last[i] = i_line_in;
        end
        repeat (DIV) @(negedge i_clock);
        count++;
    end
endmodule

// ===== sim/tb_lsp_serial_port.sv
`timescale 1ns/1ns
module tb_lsp_serial_port
    import lsp_pkg::*;
;
    logic        i_clock = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_read = 1'b0;
    logic        i_write = 1'b0;
    logic [4:0]  i_address = 5'h00;
    logic [31:0] i_writedata = 32'h0;
    logic        clk_en = 1'b1;
    logic [3:0]  be = 4'hf;
    logic [31:0] o_readdata, rd;
    logic        o_waitrequest, rx, cts_n, o_tx, o_rts, o_wake, drx, dtx;
    int          failures = 0;
    int          tests_run = 0;
    int          wakes = 0;
    // Clock and wake pulse tally
    always #5 i_clock = ~i_clock;
    always @(posedge i_clock) if (o_wake === 1'b1) wakes <= wakes + 1;

    lsp_serial_port DUT (.i_clock(i_clock), .i_srst(i_srst), .i_clk_en(clk_en),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(be), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_rx(rx), .i_cts(cts_n), .o_tx(o_tx),
        .o_rts(o_rts), .o_wake(o_wake), .o_dma_rx_req(drx), .o_dma_tx_req(dtx));
    lsp_remote_model #(.DIV(16)) PEER (.i_clock(i_clock), .i_line_in(o_tx),
        .o_line_out(rx), .o_clear_n(cts_n));

    task end_sim;
        $display("Checks %0d, errors %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One access; request held until waitrequest is seen low
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clock);
        i_write <= w;
        i_read <= !w;
        i_address <= a;
        i_writedata <= d;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 64);
        // Pre-edge values: data is taken and the request dropped at this edge
        rd = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        if (n >= 64) begin
            failures++;
            end_sim;
        end
    endtask
    task rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // Poll for a byte, then pop it
    task rx_chk(input logic [7:0] b, input logic dma);
        int n;
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rd[SB_NE] !== 1'b1 && n < 200);
        if (rd[SB_NE] !== 1'b1) begin
            failures++;
            end_sim;
        end
        chk("rx dma", {31'h0, dma}, {31'h0, drx});
        rdc("rx byte", OFS_DATA, {24'h0, b});
    endtask
    task tx_chk(input logic [7:0] b);
        int c;
        c = PEER.count;
        for (int n = 0; n < 3000 && PEER.count == c; n++) @(posedge i_clock);
        if (PEER.count == c) begin
            failures++;
            end_sim;
        end
        chk("tx byte", {24'h0, b}, {24'h0, PEER.last});
    endtask
    // No frame may leave while held back
    task held_chk;
        int c;
        c = PEER.count;
        repeat (400) @(posedge i_clock);
        chk("frames held", 32'(c), 32'(PEER.count));
    endtask

    initial begin
        repeat (50000) @(posedge i_clock);
        failures++;
        end_sim;
    end
    initial begin
        repeat (5) @(posedge i_clock);
        i_srst <= 1'b0;
        rdc("ctrl", OFS_CTRL, 32'h0000_0200);
        rdc("baud int", OFS_BAUDI, 32'h0000_0174);
        rdc("pattern", OFS_WAKE, 32'h0);
        rdc("data", OFS_DATA, 32'h0);
        bus(1'b1, 5'h04, 32'hffff_ffff);
        rdc("hole", 5'h04, 32'h0);
        bus(1'b1, OFS_BAUDF, 32'h0000_01a5);
        rdc("baud frac", OFS_BAUDF, 32'h0000_00a5);
        bus(1'b1, OFS_BAUDF, 32'h0);
        // Fraction lives in lane 0 only
        be <= 4'he;
        bus(1'b1, OFS_BAUDF, 32'hff);
        be <= 4'hf;
        rdc("frac lanes", OFS_BAUDF, 32'h0);
        // Divisor 16 is large enough for three samples
        bus(1'b1, OFS_BAUDI, 32'h10);
        rdc("baud int", OFS_BAUDI, 32'h10);
        bus(1'b1, OFS_CTRL, 32'h0000_0028);
        @(posedge i_clock);
        chk("tx dma", 32'h1, {31'h0, dtx});
        bus(1'b1, OFS_DATA, 32'h11);
        held_chk;
        bus(1'b1, OFS_CTRL, 32'h0000_002a);
        tx_chk(8'h11);
        PEER.o_clear_n <= 1'b1;
        bus(1'b1, OFS_CTRL, 32'h0000_042a);
        bus(1'b1, OFS_DATA, 32'h5a);
        held_chk;
        PEER.o_clear_n <= 1'b0;
        tx_chk(8'h5a);
        // Byte-match wake, then with stop wake off
        bus(1'b1, OFS_WAKE, 32'hffff_ff3c);
        bus(1'b1, OFS_CTRL, 32'h0000_20ca);
        PEER.send(8'h3c);
        rx_chk(8'h3c, 1'b1);
        chk("wakes", 32'h1, 32'(wakes));
        rdc("status", OFS_STATUS, 32'h0000_0082);
        PEER.send(8'h3d);
        rx_chk(8'h3d, 1'b1);
        bus(1'b1, OFS_CTRL, 32'h0000_204a);
        PEER.send(8'h3c);
        rx_chk(8'h3c, 1'b1);
        chk("wakes", 32'h1, 32'(wakes));
        // RTS at half full, dropped by flush
        bus(1'b1, OFS_CTRL, 32'h0000_080a);
        for (int i = 0; i < 4; i++) begin
            PEER.send(8'(i));
            repeat (20) @(posedge i_clock);
            if (i >= 2) chk("rts", {31'h0, i == 3}, {31'h0, o_rts});
        end
        bus(1'b1, OFS_CTRL, 32'h0000_080e);
        repeat (3) @(posedge i_clock);
        chk("rts flushed", 32'h0, {31'h0, o_rts});
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("empty", 32'h0, {31'h0, rd[SB_NE]});
        // Frame-match wake; the oldest byte sits in the low lane
        bus(1'b1, OFS_WAKE, 32'h4433_2211);
        bus(1'b1, OFS_CTRL, 32'h0000_30ca);
        for (int i = 1; i < 5; i++) begin
            PEER.send(8'(i * 17));
            repeat (20) @(posedge i_clock);
        end
        chk("frame wakes", 32'h2, 32'(wakes));
        // Loopback with single sampling; the flush drops the frame bytes
        bus(1'b1, OFS_CTRL, 32'h0000_401e);
        bus(1'b1, OFS_DATA, 32'h96);
        rx_chk(8'h96, 1'b0);
        end_sim;
    end
endmodule
